// *** src/card_cfg_pkg.sv ***
package card_cfg_pkg;

  // Byte offsets in configuration space
  localparam logic [7:0] OFF_CLASS_CODE = 8'h08;
  localparam logic [7:0] OFF_SUBSYS = 8'h2C;
  localparam logic [7:0] OFF_SUBSYS_ALIAS = 8'h50;
  localparam logic [7:0] OFF_CLASS_ALIAS = 8'h54;
  localparam logic [7:0] OFF_SOCKET_CFG = 8'h58;
  localparam logic [7:0] OFF_POWER_DELAY = 8'h5C;

  localparam logic [31:0] CLASS_ALIAS_RESET = 32'h0780_0000;
  localparam logic [31:0] CLASS_ALIAS_WMASK = 32'hFFFF_FF00;
  localparam logic [31:0] SOCKET_CFG_RESET = 32'h0110_1101;
  localparam logic [31:0] SOCKET_CFG_WMASK = 32'hF111_1111;
  localparam logic [31:0] SOCKET0_BITS = 32'h0111_1111;
  localparam logic [31:0] POWER_DELAY_RESET = 32'h0000_0000;
  localparam logic [31:0] POWER_DELAY_MASK = 32'h0000_FF00;

  // Field positions of the socket configuration and power delay words
  localparam int SCRATCH_LSB = 28;
  localparam int HIGH_VOLT_BIT = 24;
  localparam int LOW_VOLT_BIT = 20;
  localparam int EMV_BIT = 16;
  localparam int GP_PINS_BIT = 12;
  localparam int PC_CARD_BIT = 8;
  localparam int INSERT_WAKE_BIT = 4;
  localparam int SOCK_ON_BIT = 0;
  localparam int SETTLE_LSB = 8;

  typedef struct packed {
    logic [31:0] subsys;
    logic [31:0] class_code;
    logic [31:0] socket_cfg;
    logic [31:0] power_delay;
    logic loading;
    logic wake_pulse;
    logic [31:0] rdata;
  } state_s;

endpackage

// *** src/card_cfg_regs.sv ***
// Notes on behaviour
// - Subsystem alias upper half appears as subsystem device identifier.
// - Subsystem alias lower half appears as subsystem vendor identifier.
// - Subsystem alias returns to default only on global reset.
// - Class alias writable and EEPROM loadable; original class code read-only.
// - Socket config word mixes writable and read-only bits, EEPROM loadable.
// - Reserved socket config bits read zero and ignore writes.
// - High-voltage class bit one means socket 0 supports class B.
// - Low-voltage class bit one means socket 0 supports class A.
// - EMV interface of socket 0 enabled only while its bit is one.
// - Socket 0 general purpose pins enabled only while their bit is one.
// - Card insertion raises wake event when insert wake and socket enable bits are both one.
// - Socket 0 operates only while the socket enable bit is one.
// - Bits of an unimplemented socket are held at zero.
// - Socket config word is mirrored into a global control alias.
// - Power switch settling time in ms, read-only, no hardware effect.
// - Reserved upper half and low byte of delay word read zero.
`timescale 1ns/1ns
`default_nettype none
module card_cfg_regs #(
  parameter logic [31:0] SUBSYS_RESET = 32'h0000_0001, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h00, // Arbitrary value
  parameter bit SOCK0_PRESENT = 1'b1
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rstn, // Global reset, active low
  input wire logic cfg_wr, // Config write strobe
  input wire logic cfg_rd, // Config read strobe
  input wire logic [7:0] cfg_addr, // Config byte offset
  input wire logic [31:0] cfg_wdata, // Config write data
  input wire logic [3:0] cfg_be, // Config byte enables
  output logic [31:0] cfg_rdata, // Config read data
  input wire logic ee_wr, // EEPROM load word strobe
  input wire logic [7:0] ee_addr, // EEPROM load offset
  input wire logic [31:0] ee_data, // EEPROM load data
  input wire logic ee_done, // EEPROM load finished
  input wire logic card_insert, // Socket 0 insertion pulse
  output logic [15:0] subsys_device_ident, // Subsystem device id
  output logic [15:0] subsys_vendor_ident, // Subsystem vendor id
  output logic [31:0] class_code_word, // Class code seen by config
  output logic [31:0] global_cfg1_alias, // Mirror of socket config
  output logic [31:0] global_cfg2_alias, // Mirror of delay word
  output logic sock0_on, // Socket 0 enabled
  output logic sock0_high_volt_class, // Class B supported
  output logic sock0_low_volt_class, // Class A supported
  output logic sock0_emv_if_on, // EMV interface enabled
  output logic sock0_gp_pins_on, // card_gp_pins enabled
  output logic sock0_pc_card_mode, // PC card mode
  output logic sock0_insert_wake, // Insertion wake enabled
  output logic [7:0] pc_card_power_settle_ms, // Power settle time
  output logic pme_event, // Wake event pulse
  output logic loading // EEPROM load window open
);

  localparam logic [31:0] SOCK_KEEP =
    SOCK0_PRESENT ? 32'hFFFF_FFFF : ~card_cfg_pkg::SOCKET0_BITS;

  // Field positions must fit inside the 32-bit words
  if (card_cfg_pkg::SCRATCH_LSB + 4 > 32) begin : g_scratch_chk
    $error("scratch field outside word");
  end
  if (card_cfg_pkg::SETTLE_LSB + 8 > 32) begin : g_settle_chk
    $error("settle field outside word");
  end

  card_cfg_pkg::state_s state_r;
  card_cfg_pkg::state_s state_nxt;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (wdata & m);
  endfunction

  always_comb begin
    state_nxt = state_r;
    state_nxt.wake_pulse = 1'b0;
    // Writes from software
    if (cfg_wr) begin
      if (cfg_addr == card_cfg_pkg::OFF_SUBSYS_ALIAS) begin
        state_nxt.subsys = merge(state_r.subsys, cfg_wdata, cfg_be,
                                 32'hFFFF_FFFF);
      end else if (cfg_addr == card_cfg_pkg::OFF_CLASS_ALIAS) begin
        state_nxt.class_code = merge(state_r.class_code, cfg_wdata, cfg_be,
                                     card_cfg_pkg::CLASS_ALIAS_WMASK);
      end else if (cfg_addr == card_cfg_pkg::OFF_SOCKET_CFG) begin
        state_nxt.socket_cfg = merge(state_r.socket_cfg, cfg_wdata, cfg_be,
          card_cfg_pkg::SOCKET_CFG_WMASK & SOCK_KEEP);
      end
    end
    // EEPROM load after global reset, overrides a same-cycle write
    if (state_r.loading && ee_wr) begin
      if (ee_addr == card_cfg_pkg::OFF_SUBSYS_ALIAS) begin
        state_nxt.subsys = ee_data;
      end else if (ee_addr == card_cfg_pkg::OFF_CLASS_ALIAS) begin
        state_nxt.class_code = merge(state_r.class_code, ee_data, 4'hF,
                                     card_cfg_pkg::CLASS_ALIAS_WMASK);
      end else if (ee_addr == card_cfg_pkg::OFF_SOCKET_CFG) begin
        state_nxt.socket_cfg = ee_data &
          card_cfg_pkg::SOCKET_CFG_WMASK & SOCK_KEEP;
      end else if (ee_addr == card_cfg_pkg::OFF_POWER_DELAY) begin
        state_nxt.power_delay = ee_data &
          card_cfg_pkg::POWER_DELAY_MASK;
      end
    end
    if (ee_done) begin
      state_nxt.loading = 1'b0;
    end
    if (card_insert &&
        state_r.socket_cfg[card_cfg_pkg::INSERT_WAKE_BIT] &&
        state_r.socket_cfg[card_cfg_pkg::SOCK_ON_BIT]) begin
      state_nxt.wake_pulse = 1'b1;
    end
    // Registered read data, zero for unmapped offsets
    if (cfg_rd) begin
      if (cfg_addr == card_cfg_pkg::OFF_CLASS_CODE) begin
        state_nxt.rdata = {state_r.class_code[31:8], REVISION};
      end else if (cfg_addr == card_cfg_pkg::OFF_SUBSYS) begin
        state_nxt.rdata = state_r.subsys;
      end else if (cfg_addr == card_cfg_pkg::OFF_SUBSYS_ALIAS) begin
        state_nxt.rdata = state_r.subsys;
      end else if (cfg_addr == card_cfg_pkg::OFF_CLASS_ALIAS) begin
        state_nxt.rdata = {state_r.class_code[31:8], REVISION};
      end else if (cfg_addr == card_cfg_pkg::OFF_SOCKET_CFG) begin
        state_nxt.rdata = state_r.socket_cfg;
      end else if (cfg_addr == card_cfg_pkg::OFF_POWER_DELAY) begin
        state_nxt.rdata = state_r.power_delay;
      end else begin
        state_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r.subsys <= SUBSYS_RESET;
      state_r.class_code <= card_cfg_pkg::CLASS_ALIAS_RESET;
      state_r.socket_cfg <= card_cfg_pkg::SOCKET_CFG_RESET & SOCK_KEEP;
      state_r.power_delay <= card_cfg_pkg::POWER_DELAY_RESET;
      state_r.loading <= 1'b1;
      state_r.wake_pulse <= 1'b0;
      state_r.rdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cfg_rdata = state_r.rdata;
  assign subsys_device_ident = state_r.subsys[31:16];
  assign subsys_vendor_ident = state_r.subsys[15:0];
  assign class_code_word = {state_r.class_code[31:8], REVISION};
  assign global_cfg1_alias = state_r.socket_cfg;
  assign global_cfg2_alias = state_r.power_delay;
  assign sock0_on = state_r.socket_cfg[card_cfg_pkg::SOCK_ON_BIT];
  assign sock0_high_volt_class =
    state_r.socket_cfg[card_cfg_pkg::HIGH_VOLT_BIT];
  assign sock0_low_volt_class =
    state_r.socket_cfg[card_cfg_pkg::LOW_VOLT_BIT];
  assign sock0_emv_if_on = state_r.socket_cfg[card_cfg_pkg::EMV_BIT];
  assign sock0_gp_pins_on =
    state_r.socket_cfg[card_cfg_pkg::GP_PINS_BIT];
  // Software keeps this equal to the socket select
  assign sock0_pc_card_mode =
    state_r.socket_cfg[card_cfg_pkg::PC_CARD_BIT];
  assign sock0_insert_wake =
    state_r.socket_cfg[card_cfg_pkg::INSERT_WAKE_BIT];
  assign pc_card_power_settle_ms =
    state_r.power_delay[card_cfg_pkg::SETTLE_LSB +: 8];
  assign pme_event = state_r.wake_pulse;
  assign loading = state_r.loading;

endmodule
`default_nettype wire

// *** tb/card_cfg_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module card_cfg_asserts (
  input wire logic clk, rstn, cfg_wr, cfg_rd, ee_wr, ee_done, card_insert,
  input wire logic pme_event, loading,
  input wire logic [7:0] cfg_addr, pc_card_power_settle_ms,
  input wire logic [3:0] cfg_be,
  input wire logic [15:0] subsys_device_ident, subsys_vendor_ident,
  input wire logic [31:0] cfg_wdata, class_code_word, global_cfg1_alias,
  input wire logic [31:0] global_cfg2_alias
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic ok = cfg_wr && !ee_wr && cfg_be == 4'hF;
  wire logic wk = card_insert && global_cfg1_alias[4] && global_cfg1_alias[0];
  wake_on_a: assert property (wk |=> pme_event) else $error("no wake");
  no_wake_a: assert property (!wk |=> !pme_event) else $error("stray");
  rsvd_zero_a: assert property (~|(global_cfg1_alias & 32'h0EEE_EEEE))
    else $error("reserved bits set");
  delay_word_a: assert property (global_cfg2_alias ==
    {16'h0000, pc_card_power_settle_ms, 8'h00}) else $error("delay word");
  sock_write_a: assert property (ok && cfg_addr == 8'h58 |=>
    global_cfg1_alias == ($past(cfg_wdata) & card_cfg_pkg::SOCKET_CFG_WMASK))
    else $error("socket word not written");
  subsys_write_a: assert property (ok && cfg_addr == 8'h50 |=>
    {subsys_device_ident, subsys_vendor_ident} == $past(cfg_wdata))
    else $error("subsystem ids not written");
  class_write_a: assert property (ok && cfg_addr == 8'h54 |=>
    class_code_word[31:8] == $past(cfg_wdata[31:8])) else $error("class");
  load_close_a: assert property (ee_done |=> !loading) else $error("open");
  cover property (pme_event);
  cover property (ee_done);
  cover property (cfg_rd && cfg_addr == 8'h58);
endmodule
bind card_cfg_regs card_cfg_asserts card_cfg_asserts_i (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, ee_wr = 1'b0;
  logic ee_done = 1'b0, card_insert = 1'b0, pme_event, loading, sock0_on;
  logic sock0_high_volt_class, sock0_low_volt_class, sock0_emv_if_on;
  logic sock0_gp_pins_on, sock0_pc_card_mode, sock0_insert_wake;
  logic [7:0] cfg_addr = 8'h00, pc_card_power_settle_ms;
  logic [15:0] subsys_device_ident, subsys_vendor_ident;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, class_code_word;
  logic [31:0] global_cfg1_alias, global_cfg2_alias;
  logic [3:0] cfg_be = 4'hF;
  wire logic [7:0] ee_addr = cfg_addr;
  wire logic [31:0] ee_data = cfg_wdata;
  localparam logic [4:0] RD = 5'h01, WR = 5'h02, EE = 5'h04, DN = 5'h08;
  localparam logic [4:0] INS = 5'h10;
  int bad_count = 0, check_count = 0;
  card_cfg_regs card_cfg_regs_i (.*);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    bad_count += (seen !== exp);
    if (seen !== exp)
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
  endtask
  task automatic acc(input logic [4:0] k, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {card_insert, ee_done, ee_wr, cfg_wr, cfg_rd} <= k;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    {card_insert, ee_done, ee_wr, cfg_wr, cfg_rd} <= 5'h00;
    @(negedge clk);
    if (k[0] || k[4])
      chk(k[0] ? cfg_rdata : {31'h0, pme_event}, d);
  endtask
  task report_and_stop;
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    acc(RD, 8'h58, 32'h0110_1101);
    acc(RD, 8'h50, 32'h0000_0001);
    chk(loading, 1'b1);
    acc(EE, 8'h5C, 32'hFFFF_FFFF);
    acc(EE, 8'h58, 32'hFFFF_FFFF);
    acc(RD, 8'h58, 32'hF111_1111);
    chk({sock0_high_volt_class, sock0_low_volt_class, sock0_emv_if_on,
      sock0_gp_pins_on, sock0_pc_card_mode, sock0_insert_wake, sock0_on},
      7'h7F);
    acc(DN, 8'h00, 32'h0);
    acc(EE, 8'h5C, 32'h0);
    acc(WR, 8'h5C, 32'h0);
    acc(RD, 8'h5C, 32'h0000_FF00);
    chk(pc_card_power_settle_ms, 8'hFF);
    chk(global_cfg2_alias, 32'h0000_FF00);
    chk(loading, 1'b0);
    acc(WR, 8'h58, 32'h10);
    acc(INS, 8'h00, 32'h0);
    acc(WR, 8'h58, 32'h11);
    acc(INS, 8'h00, 32'h1);
    chk(global_cfg1_alias, 32'h0000_0011);
    acc(WR, 8'h50, 32'h1234_5678);
    acc(RD, 8'h2C, 32'h1234_5678);
    chk({subsys_device_ident, subsys_vendor_ident}, 32'h1234_5678);
    @(posedge clk);
    cfg_be <= 4'h3;
    acc(WR, 8'h50, 32'hFFFF_FFFF);
    acc(RD, 8'h50, 32'h1234_FFFF);
    @(posedge clk);
    cfg_be <= 4'hF;
    acc(WR, 8'h54, 32'hFFFF_FFFF);
    acc(RD, 8'h08, 32'hFFFF_FF00);
    chk(class_code_word, 32'hFFFF_FF00);
    acc(RD, 8'h54, 32'hFFFF_FF00);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    acc(RD, 8'h50, 32'h0000_0001);
    acc(RD, 8'h58, 32'h0110_1101);
    chk(loading, 1'b1);
    report_and_stop;
  end
endmodule
`default_nettype wire
